/* pkg/cmc_pkg.sv */
// shared types and constants for the cpu control and strobe block
package cmc_pkg;
   typedef enum logic [2:0] {
      CMC_TI = 3'b000,
      CMC_T1 = 3'b001,
      CMC_T2 = 3'b010,
      CMC_T3 = 3'b011,
      CMC_TW = 3'b100,
      CMC_T4 = 3'b101
   } cmc_tstate_t;
   localparam logic [7:0] NMI_TYPE = 8'h02;
   localparam logic [1:0] IRQ_ACK_STROBE_N_CYCLES = 2'h2;
   localparam int VEC_SHIFT = 2;
   localparam int VEC_ADDR_W_DEF = 20;
   localparam int VEC_ADDR_W_MIN = 10;
   localparam int RESET_MIN_CLK = 4;
   localparam int PIN_IRQ = 0;
   localparam int PIN_NMI = 1;
   localparam int PIN_RESUME = 2;
   localparam int PIN_RST = 3;
   localparam int PIN_N = 4;
   localparam logic MEM_IO_RST = 1'b1;
   localparam logic MIN_MODE_RST = 1'b1;
endpackage

/* pkg/cmc_bus_if.sv */
// link between the control logic and the bus state sequencer
`timescale 1ns/1ns
`default_nettype none
interface cmc_bus_if;
   import cmc_pkg::*;
   logic start;
   logic ready;
   logic abort;
   logic accept;
   cmc_tstate_t tstate;
   modport ctl(output start, output ready, output abort, input accept, input tstate);
   modport seq(input start, input ready, input abort, output accept, output tstate);
endinterface
`default_nettype wire

/* design/cmc_tseq.sv */
// bus cycle state sequencer t1 t2 t3 tw t4
`timescale 1ns/1ns
`default_nettype none
module cmc_tseq
   import cmc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   cmc_bus_if.seq bif
);
   cmc_tstate_t st_q, st_d;
   logic cyc_end;

   assign bif.tstate = st_q;
   assign cyc_end = (st_q == CMC_TI) || (st_q == CMC_T4);
   assign bif.accept = bif.start && !bif.abort && cyc_end;

   always_comb begin
      st_d = st_q;
      case (st_q)
         CMC_TI: if (bif.accept) st_d = CMC_T1;
         CMC_T1: st_d = CMC_T2;
         CMC_T2: st_d = CMC_T3;
         CMC_T3: st_d = bif.ready ? CMC_T4 : CMC_TW;
         CMC_TW: st_d = bif.ready ? CMC_T4 : CMC_TW;
         CMC_T4: st_d = bif.accept ? CMC_T1 : CMC_TI;
         default: st_d = CMC_TI;
      endcase
      if (bif.abort) begin
         st_d = CMC_TI;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= CMC_TI;
      end else begin
         st_q <= st_d;
      end
   end

   t_order_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (st_q == CMC_T1) && !bif.abort |=> (st_q == CMC_T2) ##1 (st_q == CMC_T3) || bif.abort)
      else $error("t1 not followed by t2 and t3");
   wait_ins_a: assert property (@(posedge core_clk) disable iff (!rstn)
      ((st_q == CMC_T3) || (st_q == CMC_TW)) && !bif.ready && !bif.abort |=> st_q == CMC_TW)
      else $error("no wait state while bus not ready");
   wait_seen_c: cover property (@(posedge core_clk) disable iff (!rstn)
      (st_q == CMC_TW) ##1 (st_q == CMC_T4));
endmodule
`default_nettype wire

/* design/cmc_ctrl.sv */
// interrupt, wait, reset inputs and minimum mode bus strobes
`timescale 1ns/1ns
`default_nettype none
// Operation
// - sync irq level, sample at instruction end
// - irq ignored when enable flag clear
// - handler address looked up from vector table; the block only outputs the table entry address, type times four
// - wait continues on resume low, else idles
// - resume input synchronised every clock
// - nmi edge triggered, always type two
// - nmi rising edge, unmaskable, instruction end
// - synced reset abandons current activity at once
// - restart from defined state on reset release
// - strap selects mode; high means minimum
// - memory io status high memory, low io
// - status valid from t1 to final t4
// - status floats resting high in hold
// - write strobe low in t2 t3 tw
// - write strobe floats resting high in hold
// - ack strobe low in t2 t3 tw
// - ack strobe always driven
// - address latch pulse high in t1
// - address latch pulse always driven
// - hold ack raised in t4 or idle
module cmc_ctrl
   import cmc_pkg::*;
#(
   parameter int VEC_ADDR_W = VEC_ADDR_W_DEF
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic reset_pin,
   input wire logic bus_mode_strap,
   input wire logic maskable_irq,
   input wire logic nmi_pin,
   input wire logic resume_n,
   input wire logic hold_req,
   input wire logic bus_ready,
   input wire logic [7:0] bus_data_in,
   input wire logic instr_last,
   input wire logic irq_enable,
   input wire logic wait_exec,
   input wire logic core_req,
   input wire logic core_write,
   input wire logic core_io,
   output logic core_grant,
   output logic core_done,
   output logic core_restart,
   output logic irq_busy,
   output logic vec_valid,
   output logic [7:0] vec_type,
   output logic [VEC_ADDR_W-1:0] vec_addr,
   output logic wait_resume,
   output logic wait_idle,
   output logic mem_io_o,
   output logic mem_io_oe_n,
   output logic write_n_o,
   output logic write_oe_n,
   output logic irq_ack_strobe_n,
   output logic addr_latch,
   output logic bus_release_ack,
   output logic min_mode
);
   generate
      if (VEC_ADDR_W < VEC_ADDR_W_MIN) begin : g_bad_w
         $error("vector address too narrow");
      end
   endgenerate

   cmc_bus_if bif();
   cmc_tseq u_seq (
      .core_clk(core_clk),
      .rstn(rstn),
      .bif(bif)
   );

   cmc_tstate_t tstate;
   logic [PIN_N-1:0] pins, sync1_q, sync1_d, sync2_q, sync2_d;
   logic irq_s, nmi_s, resume_s, rst_s;
   logic nmi_prev_q, nmi_prev_d, nmi_pend_q, nmi_pend_d;
   logic [1:0] irq_ack_strobe_n_left_q, irq_ack_strobe_n_left_d;
   logic cur_irq_ack_strobe_n_q, cur_irq_ack_strobe_n_d, cur_last_q, cur_last_d, cur_write_q, cur_write_d;
   logic mem_io_q, mem_io_d, hold_q, hold_d;
   logic strap_done_q, strap_done_d, min_q, min_d;
   logic rst_prev_q, rst_prev_d, restart_q, restart_d;
   logic vec_valid_q, vec_valid_d;
   logic [7:0] vec_type_q, vec_type_d;
   logic [VEC_ADDR_W-1:0] vec_addr_q, vec_addr_d;
   logic nmi_edge, in_t4i, hold_enter, strobe_win, take_nmi, take_irq;
   logic acc_irq_ack_strobe_n, cap;

   assign tstate = bif.tstate;
   assign pins = {reset_pin, resume_n, nmi_pin, maskable_irq};

   // two flop synchronisers for all asynchronous pins
   always_comb begin
      sync1_d = pins;
      sync2_d = sync1_q;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
      end
   end

   assign irq_s = sync2_q[PIN_IRQ];
   assign nmi_s = sync2_q[PIN_NMI];
   assign resume_s = sync2_q[PIN_RESUME];
   assign rst_s = sync2_q[PIN_RST];

   assign nmi_edge = nmi_s && !nmi_prev_q;
   assign in_t4i = (tstate == CMC_TI) || (tstate == CMC_T4);
   assign hold_enter = min_q && hold_req && !hold_q && in_t4i && !rst_s;
   assign strobe_win = (tstate == CMC_T2) || (tstate == CMC_T3) || (tstate == CMC_TW);
   assign take_nmi = instr_last && nmi_pend_q && (irq_ack_strobe_n_left_q == 2'h0) && !rst_s;
   assign take_irq = instr_last && !nmi_pend_q && irq_s && irq_enable
      && (irq_ack_strobe_n_left_q == 2'h0) && !rst_s;
   assign acc_irq_ack_strobe_n = bif.accept && (irq_ack_strobe_n_left_q != 2'h0);
   // second acknowledge cycle delivers the vector type
   assign cap = cur_irq_ack_strobe_n_q && cur_last_q && bus_ready
      && ((tstate == CMC_T3) || (tstate == CMC_TW));

   assign bif.start = min_q && !hold_q && !hold_enter && !rst_s
      && ((irq_ack_strobe_n_left_q != 2'h0) || core_req);
   assign bif.ready = bus_ready;
   assign bif.abort = rst_s;

   always_comb begin
      nmi_prev_d = nmi_s;
      nmi_pend_d = (nmi_pend_q && !take_nmi) || nmi_edge;
      irq_ack_strobe_n_left_d = irq_ack_strobe_n_left_q;
      cur_irq_ack_strobe_n_d = cur_irq_ack_strobe_n_q;
      cur_last_d = cur_last_q;
      cur_write_d = cur_write_q;
      mem_io_d = mem_io_q;
      hold_d = hold_q;
      strap_done_d = strap_done_q;
      min_d = min_q;
      rst_prev_d = rst_s;
      restart_d = rst_prev_q && !rst_s;
      vec_valid_d = take_nmi || cap;
      vec_type_d = vec_type_q;
      if (take_irq) begin
         irq_ack_strobe_n_left_d = IRQ_ACK_STROBE_N_CYCLES;
      end else if (acc_irq_ack_strobe_n) begin
         irq_ack_strobe_n_left_d = irq_ack_strobe_n_left_q - 2'h1;
      end
      if (bif.accept) begin
         cur_irq_ack_strobe_n_d = acc_irq_ack_strobe_n;
         cur_last_d = acc_irq_ack_strobe_n && (irq_ack_strobe_n_left_q == 2'h1);
         cur_write_d = !acc_irq_ack_strobe_n && core_write;
         mem_io_d = !acc_irq_ack_strobe_n && !core_io;
      end
      if (hold_enter) begin
         hold_d = 1'b1;
      end else if (hold_q && !hold_req) begin
         hold_d = 1'b0;
      end
      if (!strap_done_q || rst_s) begin
         min_d = bus_mode_strap;
         strap_done_d = 1'b1;
      end
      if (take_nmi) begin
         vec_type_d = NMI_TYPE;
      end else if (cap) begin
         vec_type_d = bus_data_in;
      end
      if (rst_s) begin
         nmi_pend_d = 1'b0;
         irq_ack_strobe_n_left_d = 2'h0;
         cur_irq_ack_strobe_n_d = 1'b0;
         cur_last_d = 1'b0;
         cur_write_d = 1'b0;
         hold_d = 1'b0;
         vec_valid_d = 1'b0;
      end
      vec_addr_d = VEC_ADDR_W'(vec_type_d) << VEC_SHIFT;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         nmi_prev_q <= 1'b0;
         nmi_pend_q <= 1'b0;
         irq_ack_strobe_n_left_q <= 2'h0;
         cur_irq_ack_strobe_n_q <= 1'b0;
         cur_last_q <= 1'b0;
         cur_write_q <= 1'b0;
         mem_io_q <= MEM_IO_RST;
         hold_q <= 1'b0;
         strap_done_q <= 1'b0;
         min_q <= MIN_MODE_RST;
         rst_prev_q <= 1'b0;
         restart_q <= 1'b0;
         vec_valid_q <= 1'b0;
         vec_type_q <= 8'h00;
         vec_addr_q <= '0;
      end else begin
         nmi_prev_q <= nmi_prev_d;
         nmi_pend_q <= nmi_pend_d;
         irq_ack_strobe_n_left_q <= irq_ack_strobe_n_left_d;
         cur_irq_ack_strobe_n_q <= cur_irq_ack_strobe_n_d;
         cur_last_q <= cur_last_d;
         cur_write_q <= cur_write_d;
         mem_io_q <= mem_io_d;
         hold_q <= hold_d;
         strap_done_q <= strap_done_d;
         min_q <= min_d;
         rst_prev_q <= rst_prev_d;
         restart_q <= restart_d;
         vec_valid_q <= vec_valid_d;
         vec_type_q <= vec_type_d;
         vec_addr_q <= vec_addr_d;
      end
   end

   // pin drivers; pins floated in hold still show their resting level
   assign mem_io_o = mem_io_q || hold_q;
   assign mem_io_oe_n = hold_q || !min_q;
   assign write_n_o = !(min_q && cur_write_q && strobe_win);
   assign write_oe_n = hold_q || !min_q;
   assign irq_ack_strobe_n = !(min_q && cur_irq_ack_strobe_n_q && strobe_win);
   assign addr_latch = min_q && (tstate == CMC_T1);
   assign bus_release_ack = hold_q;
   assign min_mode = min_q;

   assign core_grant = bif.accept && !acc_irq_ack_strobe_n;
   assign core_done = (tstate == CMC_T4) && !cur_irq_ack_strobe_n_q;
   assign core_restart = restart_q;
   assign irq_busy = (irq_ack_strobe_n_left_q != 2'h0) || (cur_irq_ack_strobe_n_q && (tstate != CMC_TI));
   assign vec_valid = vec_valid_q;
   assign vec_type = vec_type_q;
   assign vec_addr = vec_addr_q;
   assign wait_resume = wait_exec && !resume_s;
   assign wait_idle = wait_exec && resume_s;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   irq_take_a: assert property (
      take_irq |=> irq_ack_strobe_n_left_q == IRQ_ACK_STROBE_N_CYCLES ##1 1'b1)
      else $error("accepted irq did not start acknowledge");
   irq_mask_a: assert property (
      instr_last && !irq_enable && !nmi_pend_q && (irq_ack_strobe_n_left_q == 2'h0) |=> irq_ack_strobe_n_left_q == 2'h0)
      else $error("masked irq started acknowledge");
   vec_addr_a: assert property (
      vec_valid_q |-> vec_addr_q == (VEC_ADDR_W'(vec_type_q) << VEC_SHIFT))
      else $error("vector address not type times four");
   wait_hold_a: assert property (
      wait_exec && $past(resume_n, 2) && $past(rstn, 2) |-> !wait_resume && wait_idle)
      else $error("wait resumed while resume high");
   resume_sync_a: assert property (
      wait_exec && !$past(resume_n, 2) && !rst_s |-> wait_resume)
      else $error("resume not seen two clocks later");
   nmi_vec_a: assert property (
      take_nmi |=> vec_valid_q && (vec_type_q == NMI_TYPE))
      else $error("nmi did not raise type two");
   nmi_edge_a: assert property (
      nmi_edge && !rst_s |=> nmi_pend_q || vec_valid_q)
      else $error("nmi edge lost");
   reset_abort_a: assert property (
      rst_s |=> (tstate == CMC_TI) && (irq_ack_strobe_n_left_q == 2'h0) && !hold_q)
      else $error("reset did not abandon activity");
   restart_a: assert property (
      $fell(rst_s) |=> core_restart ##1 !core_restart)
      else $error("no single restart pulse");
   mio_stable_a: assert property (
      (tstate != CMC_TI) && (tstate != CMC_T4) && !rst_s |=> $stable(mem_io_q))
      else $error("status changed inside cycle");
   hold_float_a: assert property (
      bus_release_ack |-> mem_io_oe_n && mem_io_o && write_oe_n && write_n_o)
      else $error("lines driven during hold");
   write_win_a: assert property (
      min_q && cur_write_q && (tstate == CMC_T2) && !rst_s |-> !write_n_o [*2])
      else $error("write strobe missing in t2 t3");
   ack_win_a: assert property (
      !irq_ack_strobe_n |-> cur_irq_ack_strobe_n_q && strobe_win)
      else $error("ack strobe outside t2 t3 tw");
   ale_pulse_a: assert property (
      $rose(addr_latch) |-> (tstate == CMC_T1) ##1 !addr_latch)
      else $error("latch pulse not single t1 clock");
   hold_entry_a: assert property (
      $rose(bus_release_ack) |-> $past(tstate) == CMC_TI || $past(tstate) == CMC_T4)
      else $error("hold ack raised mid cycle");

   nmi_taken_c: cover property (take_nmi ##1 vec_valid_q);
   irq_ack_strobe_n_pair_c: cover property (take_irq ##[1:40] (vec_valid_q && vec_type_q != NMI_TYPE));
   hold_c: cover property ($rose(bus_release_ack) ##[1:20] $fell(bus_release_ack));
   write_c: cover property (!write_n_o ##1 (tstate == CMC_T4));
endmodule
`default_nettype wire

/* tb/cmc_far_model.sv */
// far side model: address latch and bus decode with wait states
`timescale 1ns/1ns
`default_nettype none
module cmc_far_model (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic addr_latch,
   input wire logic irq_ack_strobe_n,
   input wire logic mem_io_o,
   input wire logic [3:0] wait_cnt,
   input wire logic [7:0] ack_byte,
   output logic bus_ready,
   output logic [7:0] bus_data_in,
   output logic stat_latched
);
   logic [4:0] cnt_q;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 5'h00;
         stat_latched <= 1'b1;
      end else if (addr_latch) begin
         cnt_q <= 5'h01;
         stat_latched <= mem_io_o;
      end else if (cnt_q != 5'h1f) begin
         cnt_q <= cnt_q + 5'h01;
      end
   end
   assign bus_ready = cnt_q >= 5'(wait_cnt) + 5'h02;
   // released data bus shows the inverse of the vector byte
   assign bus_data_in = irq_ack_strobe_n ? ~ack_byte : ack_byte;
endmodule
`default_nettype wire

/* tb/cmc_ctrl_bench.sv */
// self-checking bench for the cpu control and strobe block
`timescale 1ns/1ns
`default_nettype none
module cmc_ctrl_bench;
   import cmc_pkg::*;
   logic core_clk = 0, rstn = 0, reset_pin = 0, bus_mode_strap = 1, maskable_irq = 0;
   logic nmi_pin = 0, resume_n = 1, hold_req = 0, instr_last = 0, irq_enable = 0;
   logic wait_exec = 0, core_req = 0, core_write = 0, core_io = 0;
   logic bus_ready, core_grant, core_done, core_restart, irq_busy, vec_valid, wait_resume;
   logic wait_idle, mem_io_o, mem_io_oe_n, write_n_o, write_oe_n, irq_ack_strobe_n;
   logic addr_latch, bus_release_ack, min_mode, stat_latched;
   logic [7:0] bus_data_in, vec_type, ack_byte = 8'h5a;
   logic [19:0] vec_addr;
   logic [3:0] wait_cnt = 4'h0;
   int err_total = 0, compares = 0, n, a, w;
   always #5 core_clk = ~core_clk;
   cmc_ctrl dut (.core_clk, .rstn, .reset_pin, .bus_mode_strap, .maskable_irq, .nmi_pin,
      .resume_n, .hold_req, .bus_ready, .bus_data_in, .instr_last, .irq_enable, .wait_exec,
      .core_req, .core_write, .core_io, .core_grant, .core_done, .core_restart, .irq_busy,
      .vec_valid, .vec_type, .vec_addr, .wait_resume, .wait_idle, .mem_io_o, .mem_io_oe_n,
      .write_n_o, .write_oe_n, .irq_ack_strobe_n, .addr_latch, .bus_release_ack, .min_mode);
   cmc_far_model far (.core_clk, .rstn, .addr_latch, .irq_ack_strobe_n, .mem_io_o,
      .wait_cnt, .ack_byte, .bus_ready, .bus_data_in, .stat_latched);
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic tick(int k = 1);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task automatic stop_test;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic get_grant;
      n = 0;
      while (core_grant !== 1'b1 && n < 20) begin
         tick();
         n++;
      end
   endtask
   task automatic bus_cycle(logic wr, logic io, logic [3:0] wt);
      int lo, al;
      lo = 0;
      al = 0;
      @(posedge core_clk);
      core_req <= 1'b1;
      core_write <= wr;
      core_io <= io;
      wait_cnt <= wt;
      #1;
      get_grant();
      @(posedge core_clk);
      core_req <= 1'b0;
      #1;
      n = 1;
      while (core_done !== 1'b1 && n < 20) begin
         if (addr_latch === 1'b1) begin
            chk("mem_io", !io, mem_io_o);
            al++;
         end
         lo += (write_n_o === 1'b0);
         tick();
         n++;
      end
      chk("t_count", 4 + wt, n);
      chk("latch_cnt", 1, al);
      chk("wr_low", wr ? 2 + wt : 0, lo);
      chk("stat_hold", stat_latched, mem_io_o);
   endtask
   task automatic pulse_last;
      @(posedge core_clk);
      instr_last <= 1'b1;
      @(posedge core_clk);
      instr_last <= 1'b0;
      #1;
   endtask
   task automatic irq_seq(logic en);
      int lo;
      lo = 0;
      @(posedge core_clk);
      irq_enable <= en;
      maskable_irq <= 1'b1;
      wait_cnt <= 4'h1;
      repeat (3) @(posedge core_clk);
      pulse_last();
      chk("irq_busy", en, irq_busy);
      n = 0;
      while (vec_valid !== 1'b1 && n < 30) begin
         if (irq_ack_strobe_n === 1'b0) begin
            chk("ack_stat", 0, mem_io_o);
            lo++;
         end
         tick();
         n++;
      end
      chk("irq_taken", en, vec_valid);
      chk("ack_low", en ? 6 : 0, lo);
      if (en) begin
         chk("vec_type", ack_byte, vec_type);
         chk("vec_addr", {ack_byte, 2'b00}, vec_addr);
      end
      @(posedge core_clk);
      maskable_irq <= 1'b0;
   endtask
   task automatic nmi_seq;
      @(posedge core_clk);
      irq_enable <= 1'b0;
      nmi_pin <= 1'b1;
      repeat (3) @(posedge core_clk);
      pulse_last();
      n = 0;
      while (vec_valid !== 1'b1 && n < 5) begin
         tick();
         n++;
      end
      chk("nmi_type", 8'h02, vec_type);
      chk("nmi_addr", 20'h00008, vec_addr);
      pulse_last();
      a = 0;
      repeat (5) begin
         a += (vec_valid === 1'b1);
         tick();
      end
      chk("nmi_level", 0, a);
      @(posedge core_clk);
      nmi_pin <= 1'b0;
   endtask
   task automatic wait_seq;
      @(posedge core_clk);
      wait_exec <= 1'b1;
      resume_n <= 1'b1;
      tick(3);
      chk("idle", 2'b10, {wait_idle, wait_resume});
      @(posedge core_clk);
      resume_n <= 1'b0;
      tick();
      chk("idle_sync", 2'b10, {wait_idle, wait_resume});
      tick();
      chk("resume", 2'b01, {wait_idle, wait_resume});
      @(posedge core_clk);
      wait_exec <= 1'b0;
   endtask
   task automatic hold_seq;
      @(posedge core_clk);
      hold_req <= 1'b1;
      core_req <= 1'b1;
      core_write <= 1'b1;
      tick();
      n = 0;
      while (bus_release_ack !== 1'b1 && n < 5) begin
         tick();
         n++;
      end
      chk("hold_ack", 1, bus_release_ack);
      chk("oe_float", 2'b11, {mem_io_oe_n, write_oe_n});
      chk("rest", 4'b1110, {mem_io_o, write_n_o, irq_ack_strobe_n, addr_latch});
      tick(2);
      chk("hold_grant", 0, core_grant);
      @(posedge core_clk);
      hold_req <= 1'b0;
      bus_cycle(1'b1, 1'b0, 4'h0);
      chk("oe_drive", 2'b00, {mem_io_oe_n, write_oe_n});
   endtask
   task automatic reset_seq;
      @(posedge core_clk);
      core_req <= 1'b1;
      core_write <= 1'b1;
      wait_cnt <= 4'h3;
      #1;
      get_grant();
      @(posedge core_clk);
      core_req <= 1'b0;
      reset_pin <= 1'b1;
      bus_mode_strap <= 1'b0;
      repeat (RESET_MIN_CLK) @(posedge core_clk);
      reset_pin <= 1'b0;
      #1;
      a = 0;
      w = 0;
      repeat (8) begin
         a += (core_done === 1'b1);
         w += (core_restart === 1'b1);
         tick();
      end
      chk("abandon", 0, a);
      chk("restart", 1, w);
      chk("max_mode", 2'b01, {min_mode, mem_io_oe_n});
      @(posedge core_clk);
      core_req <= 1'b1;
      tick(3);
      chk("max_grant", 0, core_grant);
      @(posedge core_clk);
      core_req <= 1'b0;
      bus_mode_strap <= 1'b1;
      reset_pin <= 1'b1;
      repeat (RESET_MIN_CLK) @(posedge core_clk);
      reset_pin <= 1'b0;
      tick(6);
      chk("min_mode", 1, min_mode);
   endtask
   initial begin
      tick();
      chk("rst_out", 6'b110100, {write_n_o, irq_ack_strobe_n, addr_latch, mem_io_o,
         mem_io_oe_n, vec_valid});
      @(posedge core_clk);
      rstn <= 1'b1;
      tick(3);
      bus_cycle(1'b1, 1'b0, 4'h0);
      bus_cycle(1'b0, 1'b1, 4'h2);
      bus_cycle(1'b1, 1'b1, 4'h1);
      bus_cycle(1'b0, 1'b0, 4'h0);
      irq_seq(1'b0);
      irq_seq(1'b1);
      nmi_seq();
      wait_seq();
      hold_seq();
      reset_seq();
      stop_test();
   end
   initial begin
      #50000;
      err_total++;
      stop_test();
   end
endmodule
`default_nettype wire
